// >>> hdl/vsf_pkg.sv
package vsf_pkg;

   // ****************************************************************
   // Frame size word layout
   // ****************************************************************
   localparam int          SIZE_W          = 13;
   localparam int          WIDTH_LSB       = 0;
   localparam int          HEIGHT_LSB      = 16;
   localparam logic [12:0] WIDTH_RESET     = 13'h0780;
   localparam logic [12:0] HEIGHT_RESET    = 13'h0438;
   localparam logic [31:0] SIZE_WORD_RESET = 32'h0438_0780;

   // ****************************************************************
   // Event line positions
   // ****************************************************************
   localparam int          EV_EOL_EARLY    = 0;
   localparam int          EV_EOL_LATE     = 1;
   localparam int          EV_SOF_EARLY    = 2;
   localparam int          EV_SOF_LATE     = 3;
   localparam int          EV_W            = 4;
   localparam int          STREAM_RESET_HOLD_CYCLES = 32;

   // ****************************************************************
   // Framing states
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_SYNC       = 4'b0001,
      ST_RUN        = 4'b0010,
      ST_DROP_LINE  = 4'b0100,
      ST_DROP_FRAME = 4'b1000
   } vsf_state_t;

endpackage

// >>> hdl/vsf_sync.sv
`timescale 1ns/100ps

module vsf_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   input  wire logic clk_i,   // Destination clock
   input  wire logic rst_i,   // Synchronous reset, active high
   input  wire logic d_i,     // Level from the other domain
   output logic      q_o      // Filtered, synchronised level
);

   logic s1;
   logic s2;
   logic s3;
   logic next_q;

   // Output follows once second and third stages agree
   always_comb begin
      next_q = q_o;
      if (s2 == s3) begin
         next_q = s3;
      end
   end

   // Three-stage chain; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (rst_i) begin
         q_o <= RESET_VALUE;
      end else begin
         q_o <= next_q;
      end
   end

endmodule // vsf_sync

// >>> hdl/vsf_framer.sv
`timescale 1ns/100ps

module vsf_framer #(
   parameter int DATA_W = 24
) (
   input  wire logic              clk_i,                        // Stream clock
   input  wire logic              stream_reset_n_i,             // Stream reset, active low
   input  wire logic              stream_clock_enable_i,        // Stream clock enable
   input  wire logic              ctrl_clk_i,                   // Control clock
   input  wire logic              ctrl_reset_n_i,               // Control reset, active low
   input  wire logic              control_port_clock_enable_i,  // Control clock enable
   input  wire logic              cfg_write_i,                  // Frame size write strobe
   input  wire logic [31:0]       cfg_data_i,                   // Frame size word
   output logic                   cfg_ack_o,                    // Write taken, one pulse
   output logic                   cfg_pending_o,                // Size not yet in stream side
   input  wire logic [DATA_W-1:0] s_axis_tdata,                 // Input pixel
   input  wire logic              s_axis_tvalid,                // Input valid
   output logic                   s_axis_tready,                // Input ready
   input  wire logic              s_axis_tuser,                 // Input start of frame
   input  wire logic              s_axis_tlast,                 // Input end of line
   output logic [DATA_W-1:0]      m_axis_tdata,                 // Output pixel
   output logic                   m_axis_tvalid,                // Output valid
   input  wire logic              m_axis_tready,                // Output ready
   output logic                   m_axis_tuser,                 // Output start of frame
   output logic                   m_axis_tlast,                 // Output end of line
   output logic [3:0]             parallel_event_lines_o        // Framing error events
);

   // ****************************************************************
   // Control domain
   // ****************************************************************
   logic        ctrl_rst;
   logic [31:0] shadow;
   logic [31:0] xfer;
   logic        dirty;
   logic        req_tgl;
   logic        ack_sync;
   logic        busy;
   logic [31:0] next_shadow;
   logic [31:0] next_xfer;
   logic        next_dirty;
   logic        next_req_tgl;
   logic        next_cfg_ack;

   assign ctrl_rst      = !ctrl_reset_n_i;
   assign busy          = req_tgl != ack_sync;
   assign cfg_pending_o = dirty || busy;

   // Write acknowledged locally, never waits on the stream side
   // Stream stalls, stream reset or a stopped stream clock cannot hang a write
   // Last write wins; a newer word waits in the shadow until the crossing is free
   always_comb begin
      next_shadow  = shadow;
      next_xfer    = xfer;
      next_dirty   = dirty;
      next_req_tgl = req_tgl;
      next_cfg_ack = cfg_ack_o;
      if (control_port_clock_enable_i) begin
         next_cfg_ack = cfg_write_i;
         if (dirty && !busy) begin
            next_xfer    = shadow;
            next_req_tgl = !req_tgl;
            next_dirty   = 1'b0;
         end
         if (cfg_write_i) begin
            next_shadow = cfg_data_i;
            next_dirty  = 1'b1;
         end
      end
   end

   // Control registers; stream reset does not reach them
   // Control reset puts the default size in the shadow and the crossing word
   always_ff @(posedge ctrl_clk_i) begin
      if (ctrl_rst) begin
         shadow    <= vsf_pkg::SIZE_WORD_RESET;
         xfer      <= vsf_pkg::SIZE_WORD_RESET;
         dirty     <= 1'b0;
         req_tgl   <= 1'b0;
         cfg_ack_o <= 1'b0;
      end else begin
         shadow    <= next_shadow;
         xfer      <= next_xfer;
         dirty     <= next_dirty;
         req_tgl   <= next_req_tgl;
         cfg_ack_o <= next_cfg_ack;
      end
   end

   // ****************************************************************
   // Crossings
   // ****************************************************************
   logic ctrl_rst_s;
   logic req_s;
   logic ack_tgl;
   logic st_rst;

   // Toggle handshake for the size word
   // Word in xfer held still while a request is open
   // Stream side samples it once the request toggle lands
   // Acknowledge toggle returns the same way

   // Control reset into the stream domain; no reset of its own
   vsf_sync #(.RESET_VALUE(1'b1)) u_rst_sync (
      .clk_i (clk_i),
      .rst_i (1'b0),
      .d_i   (ctrl_rst),
      .q_o   (ctrl_rst_s)
   );

   // Request toggle into the stream domain
   vsf_sync #(.RESET_VALUE(1'b0)) u_req_sync (
      .clk_i (clk_i),
      .rst_i (ctrl_rst_s),
      .d_i   (req_tgl),
      .q_o   (req_s)
   );

   // Acknowledge toggle back into the control domain
   vsf_sync #(.RESET_VALUE(1'b0)) u_ack_sync (
      .clk_i (ctrl_clk_i),
      .rst_i (ctrl_rst),
      .d_i   (ack_tgl),
      .q_o   (ack_sync)
   );

   // Either reset clears the stream side
   // Stream reset is not frame aligned; assertion mid-frame may tear the picture, release waits in SYNC for an input start
   // Control reset arrives through the synchroniser, a few clocks late
   assign st_rst = !stream_reset_n_i || ctrl_rst_s;

   // ****************************************************************
   // Stream domain
   // ****************************************************************
   logic [12:0]          width;
   logic [12:0]          height;
   logic [12:0]          pix;
   logic [12:0]          line;
   vsf_pkg::vsf_state_t  state;
   logic [3:0]           events;
   logic [12:0]          next_width;
   logic [12:0]          next_height;
   logic [12:0]          next_pix;
   logic [12:0]          next_line;
   logic                 next_ack_tgl;
   vsf_pkg::vsf_state_t  next_state;
   logic [3:0]           next_events;
   logic [DATA_W-1:0]    next_tdata;
   logic                 next_tvalid;
   logic                 next_tuser;
   logic                 next_tlast;
   logic                 in_fire;
   logic [12:0]          last_pix;

   // Input accepted only while enabled and output slot free or leaving
   // One output slot: a new beat only when the slot is empty or leaving
   assign s_axis_tready = stream_clock_enable_i && !st_rst
                          && (!m_axis_tvalid || m_axis_tready);
   assign in_fire       = s_axis_tvalid && s_axis_tready;

   // Last pixel index of a line
   assign last_pix      = 13'(width - 13'h0001);

   // Framing tracker and output beat
   // SYNC waits for the first input start after reset
   // RUN passes beats and checks markers against the position
   // DROP_LINE discards input up to and with its line end
   // DROP_FRAME discards input until an input start arrives
   // Everything holds while the stream enable is low
   always_comb begin
      logic [12:0] p;
      logic [12:0] l;
      logic        run;
      p            = pix;
      l            = line;
      run          = 1'b0;
      next_width   = width;
      next_height  = height;
      next_ack_tgl = ack_tgl;
      next_state   = state;
      next_events  = events;
      next_tdata   = m_axis_tdata;
      next_tvalid  = m_axis_tvalid;
      next_tuser   = m_axis_tuser;
      next_tlast   = m_axis_tlast;
      if (stream_clock_enable_i) begin
         // Early events last one enabled cycle
         next_events[vsf_pkg::EV_EOL_EARLY] = 1'b0;
         next_events[vsf_pkg::EV_SOF_EARLY] = 1'b0;
         // New size taken only on an open request
         if (req_s != ack_tgl) begin
            next_width   = cfg_data_sel(xfer, vsf_pkg::WIDTH_LSB);
            next_height  = cfg_data_sel(xfer, vsf_pkg::HEIGHT_LSB);
            next_ack_tgl = req_s;
         end
         // Output slot empties when downstream takes it
         if (m_axis_tready) begin
            next_tvalid = 1'b0;
         end
         // Accepted input beat steps the framing state
         if (in_fire) begin
            unique case (state)
               vsf_pkg::ST_RUN: begin
                  run = 1'b1;
               end
               vsf_pkg::ST_DROP_LINE: begin
                  if (s_axis_tlast) begin
                     next_state = vsf_pkg::ST_RUN;
                  end
               end
               vsf_pkg::ST_SYNC,
               vsf_pkg::ST_DROP_FRAME: begin
                  if (s_axis_tuser) begin
                     p   = 13'h0000;
                     l   = 13'h0000;
                     run = 1'b1;
                  end
               end
            endcase
         end
         if (run) begin
            next_state = vsf_pkg::ST_RUN;
            if (s_axis_tuser && !at_origin(p, l)) begin
               next_events[vsf_pkg::EV_SOF_EARLY] = 1'b1;
               p = 13'h0000;
               l = 13'h0000;
            end
            if (!s_axis_tuser && at_origin(p, l)) begin
               next_state = vsf_pkg::ST_DROP_FRAME;
               run        = 1'b0;
            end
         end
         if (run) begin
            next_tvalid = 1'b1;
            next_tdata  = s_axis_tdata;
            next_tuser  = at_origin(p, l);
            next_tlast  = 1'b1;
            if (s_axis_tlast && p != last_pix) begin
               next_events[vsf_pkg::EV_EOL_EARLY] = 1'b1;
            end else if (!s_axis_tlast && p == last_pix) begin
               next_state = vsf_pkg::ST_DROP_LINE;
            end else if (!s_axis_tlast) begin
               next_tlast = 1'b0;
            end
            // Advance position; wrap the line count at the frame height
            if (next_tlast) begin
               p = 13'h0000;
               l = (l == 13'(height - 13'h0001)) ? 13'h0000 : 13'(l + 13'h0001);
            end else begin
               p = 13'(p + 13'h0001);
            end
         end
         next_events[vsf_pkg::EV_EOL_LATE] = next_state == vsf_pkg::ST_DROP_LINE;
         next_events[vsf_pkg::EV_SOF_LATE] = next_state == vsf_pkg::ST_DROP_FRAME;
      end
      next_pix  = p;
      next_line = l;
   end

   // Stream registers, frozen while the enable is low
   // Ack toggle set opposite the request so the size is fetched again on release
   always_ff @(posedge clk_i) begin
      if (st_rst) begin
         width                  <= vsf_pkg::WIDTH_RESET;
         height                 <= vsf_pkg::HEIGHT_RESET;
         pix                    <= 13'h0000;
         line                   <= 13'h0000;
         ack_tgl                <= !req_s;
         state                  <= vsf_pkg::ST_SYNC;
         events                 <= 4'h0;
         m_axis_tdata           <= '0;
         m_axis_tvalid          <= 1'b0;
         m_axis_tuser           <= 1'b0;
         m_axis_tlast           <= 1'b0;
      end else begin
         width                  <= next_width;
         height                 <= next_height;
         pix                    <= next_pix;
         line                   <= next_line;
         ack_tgl                <= next_ack_tgl;
         state                  <= next_state;
         events                 <= next_events;
         m_axis_tdata           <= next_tdata;
         m_axis_tvalid          <= next_tvalid;
         m_axis_tuser           <= next_tuser;
         m_axis_tlast           <= next_tlast;
      end
   end

   // Early events pulse one enabled cycle; late events stand while dropping
   assign parallel_event_lines_o = events;

   // First pixel of the first line of a frame
   function automatic logic at_origin(input logic [12:0] px, input logic [12:0] ln);
      at_origin = (px == 13'h0000) && (ln == 13'h0000);
   endfunction

   // Field extraction from a frame size word
   function automatic logic [12:0] cfg_data_sel(input logic [31:0] w, input int lsb);
      cfg_data_sel = w[lsb +: vsf_pkg::SIZE_W];
   endfunction

endmodule // vsf_framer

// >>> verification/vsf_framer_chk.sv
`timescale 1ns/100ps

module vsf_framer_chk (
   input wire logic       clk_i,                       // Clock
   input wire logic       stream_reset_n_i,            // Reset
   input wire logic       stream_clock_enable_i,       // Enable
   input wire logic       ctrl_clk_i,                  // Ctrl clock
   input wire logic       ctrl_reset_n_i,              // Ctrl reset
   input wire logic       control_port_clock_enable_i, // Ctrl enable
   input wire logic       cfg_write_i,                 // Write
   input wire logic       cfg_ack_o,                   // Ack
   input wire logic       cfg_pending_o,               // Pending
   input wire logic       s_axis_tvalid,               // In valid
   input wire logic       s_axis_tready,               // In ready
   input wire logic       s_axis_tuser,                // In start
   input wire logic       s_axis_tlast,                // In end
   input wire logic       m_axis_tvalid,               // Out valid
   input wire logic       m_axis_tready,               // Out ready
   input wire logic       m_axis_tuser,                // Out start
   input wire logic       m_axis_tlast,                // Out end
   input wire logic [3:0] parallel_event_lines_o       // Events
);

   // ********
   // Helpers
   // ********
   logic rst, take_sof, take_eol, e_eol, l_eol, l_sof;

   // Reset and decoded events
   assign rst = !stream_reset_n_i || !ctrl_reset_n_i;
   assign take_sof = s_axis_tvalid && s_axis_tready && s_axis_tuser;
   assign take_eol = s_axis_tvalid && s_axis_tready && s_axis_tlast;
   assign e_eol = parallel_event_lines_o[vsf_pkg::EV_EOL_EARLY];
   assign l_eol = parallel_event_lines_o[vsf_pkg::EV_EOL_LATE];
   assign l_sof = parallel_event_lines_o[vsf_pkg::EV_SOF_LATE];

   // Output framing steps
   sequence s_out_sof;
      m_axis_tvalid && m_axis_tuser;
   endsequence
   sequence s_out_eol;
      m_axis_tvalid && m_axis_tlast;
   endsequence

   // ********
   // Checks
   // ********
   rdy_rule_a: assert property (@(posedge clk_i) disable iff (rst)
      s_axis_tready == (stream_clock_enable_i && (!m_axis_tvalid || m_axis_tready)))
      else $error("input ready wrong");
   out_hold_a: assert property (@(posedge clk_i) disable iff (rst)
      m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid && $stable({m_axis_tuser, m_axis_tlast}))
      else $error("output beat dropped");
   en_freeze_a: assert property (@(posedge clk_i) disable iff (rst)
      !stream_clock_enable_i |=> $stable({m_axis_tvalid, m_axis_tlast, parallel_event_lines_o}))
      else $error("state moved while disabled");
   sof_out_a: assert property (@(posedge clk_i) disable iff (rst)
      take_sof |=> s_out_sof) else $error("start not passed on");
   early_eol_a: assert property (@(posedge clk_i) disable iff (rst)
      $rose(e_eol) |-> s_out_eol) else $error("early end without line end");
   late_eol_a: assert property (@(posedge clk_i) disable iff (rst)
      $rose(l_eol) |-> s_out_eol) else $error("late end without line end");
   eol_hold_a: assert property (@(posedge clk_i) disable iff (rst)
      l_eol && !take_eol |=> l_eol) else $error("late end event dropped");
   late_sof_a: assert property (@(posedge clk_i) disable iff (rst)
      l_sof ##0 take_sof |=> !l_sof ##0 s_out_sof) else $error("late start not ended");
   cfg_ack_a: assert property (@(posedge ctrl_clk_i) disable iff (!ctrl_reset_n_i)
      cfg_write_i && control_port_clock_enable_i |=> cfg_ack_o && cfg_pending_o)
      else $error("write not acknowledged");
   no_ack_a: assert property (@(posedge ctrl_clk_i) disable iff (!ctrl_reset_n_i)
      !(cfg_write_i && control_port_clock_enable_i) |=> !cfg_ack_o)
      else $error("ack without write");

endmodule // vsf_framer_chk

// >>> verification/vsf_sink.sv
`timescale 1ns/100ps

module vsf_sink (
   input  wire logic clk_i,   // Stream clock
   input  wire logic en_i,    // Shared enable
   input  wire logic slow_i,  // Stall mode
   output logic      ready_o  // Ready
);

   // ********
   // Ready
   // ********
   logic next_ready;

   // Toggle when slow, frozen by the shared enable
   always_comb begin
      next_ready = ready_o;
      if (en_i) begin
         next_ready = slow_i ? (ready_o !== 1'b1) : 1'b1;
      end
   end

   // Register ready
   always_ff @(posedge clk_i) begin
      ready_o <= next_ready;
   end

endmodule // vsf_sink

// >>> verification/vsf_framer_bench.sv
`timescale 1ns/100ps

module vsf_framer_bench;

   // ********
   // Signals
   // ********
   localparam int DW = 24;
   logic          clk_i, cclk, srst_n, sen, crst_n, cen, cwr, ack, pend, slow, frz;
   logic          svalid, sready, suser, slast, mvalid, mready, muser, mlast;
   logic [31:0]   cdata;
   logic [DW-1:0] sdata, mdata;
   logic [3:0]    ev, ev_seen;
   logic [DW+1:0] oq[$];
   int            err_total, check_count, base;

   // Block and downstream sink
   vsf_framer #(.DATA_W(DW)) uut (
      .clk_i(clk_i), .stream_reset_n_i(srst_n), .stream_clock_enable_i(sen),
      .ctrl_clk_i(cclk), .ctrl_reset_n_i(crst_n), .control_port_clock_enable_i(cen),
      .cfg_write_i(cwr), .cfg_data_i(cdata), .cfg_ack_o(ack), .cfg_pending_o(pend),
      .s_axis_tdata(sdata), .s_axis_tvalid(svalid), .s_axis_tready(sready),
      .s_axis_tuser(suser), .s_axis_tlast(slast), .m_axis_tdata(mdata),
      .m_axis_tvalid(mvalid), .m_axis_tready(mready), .m_axis_tuser(muser),
      .m_axis_tlast(mlast), .parallel_event_lines_o(ev));
   vsf_sink sink (.clk_i(clk_i), .en_i(sen), .slow_i(slow), .ready_o(mready));

   // Unrelated stream and control clocks
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      cclk = 1'b0;
      forever #15 cclk = ~cclk;
   end

   // Capture output beats and events
   always @(posedge clk_i) begin
      if (mvalid && mready && sen) begin
         oq.push_back({muser, mlast, mdata});
      end
      ev_seen = ev_seen | ev;
   end

   // ********
   // Tasks
   // ********
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic settle();
      repeat (12) @(posedge clk_i);
      for (int i = 0; i < 100 && pend !== 1'b0; i++) @(posedge clk_i);
      #1;
      cmp("pending", 32'h0, pend);
   endtask

   task automatic cfg(input logic [31:0] w, input logic en, ackx, wt);
      @(posedge cclk);
      #1;
      {cen, cdata, cwr} = {en, w, 1'b1};
      @(posedge cclk);
      #1;
      {cen, cwr} = 2'b10;
      cmp("ack", ackx, ack);
      if (wt) settle();
   endtask

   task automatic beat(input logic u, l, input logic [DW-1:0] d);
      int n;
      if (frz && d[0]) begin
         sen = 1'b0;
         repeat (3) @(posedge clk_i);
         #1 sen = 1'b1;
      end
      {svalid, suser, slast, sdata} = {1'b1, u, l, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (sready !== 1'b1 && n < 100);
      #1;
   endtask

   task automatic run(input int n, input logic [15:0] um, lm, keep, ou, ol,
                      input logic [3:0] evx);
      int k;
      oq.delete();
      ev_seen = 4'h0;
      for (int i = 0; i < n; i++) beat(um[i], lm[i], DW'(base + i));
      svalid = 1'b0;
      for (k = 0; k < 300 && oq.size() < $countones(keep); k++) @(posedge clk_i);
      #1;
      k = 0;
      for (int i = 0; i < n; i++) begin
         if (keep[i]) begin
            cmp("beat", {ou[k], ol[k], DW'(base + i)},
                oq.size() > k ? 32'(oq[k]) : 32'hX);
            k++;
         end
      end
      cmp("count", k, oq.size());
      cmp("events", evx, ev_seen);
      cmp("events idle", 32'h0, ev);
      base += 32;
   endtask

   // ********
   // Scenarios
   // ********
   task automatic t_frame();
      run(8, 16'h01, 16'h88, 16'hFF, 16'h01, 16'h88, 4'h0);
   endtask
   task automatic t_stall();
      {slow, frz} = 2'b11;
      t_frame();
      {slow, frz} = 2'b00;
   endtask
   task automatic t_errors();
      run(6, 16'h01, 16'h22, 16'h3F, 16'h01, 16'h22, 4'h1);
      run(10, 16'h001, 16'h220, 16'h3CF, 16'h01, 16'h88, 4'h2);
      run(11, 16'h009, 16'h440, 16'h7FF, 16'h009, 16'h440, 4'h4);
      run(10, 16'h004, 16'h220, 16'h3FC, 16'h01, 16'h88, 4'h8);
   endtask
   task automatic t_ctrl_off();
      cfg(32'h0002_0002, 1'b0, 1'b0, 1'b1);
      cen = 1'b0;
      t_frame();
      cen = 1'b1;
   endtask
   task automatic t_srst();
      beat(1'b1, 1'b0, 24'h000000);
      beat(1'b0, 1'b0, 24'h000001);
      {svalid, srst_n} = 2'b00;
      cfg(32'h0002_0004, 1'b1, 1'b1, 1'b0);
      repeat (32) @(posedge clk_i);
      #1;
      cmp("stream reset", 32'h0, {sready, mvalid});
      srst_n = 1'b1;
      settle();
      t_frame();
   endtask
   task automatic t_crst();
      {srst_n, crst_n} = 2'b00;
      repeat (4) @(posedge cclk);
      #1 crst_n = 1'b1;
      repeat (32) @(posedge clk_i);
      #1 srst_n = 1'b1;
      settle();
      run(8, 16'h01, 16'h88, 16'hFF, 16'h01, 16'h88, 4'h1);
   endtask

   // Main sequence
   initial begin
      {srst_n, crst_n, cwr, svalid, suser, slast, slow, frz} = 8'h00;
      {sen, cen, cdata, sdata} = {2'b11, 32'h0, 24'h0};
      repeat (6) @(posedge clk_i);
      #1 crst_n = 1'b1;
      repeat (26) @(posedge clk_i);
      #1 srst_n = 1'b1;
      cfg(32'hE002_E004, 1'b1, 1'b1, 1'b1);
      t_frame();
      t_stall();
      t_errors();
      t_ctrl_off();
      t_srst();
      t_crst();
      results();
   end

   // Guard against a hang
   initial begin
      #200000;
      err_total++;
      results();
   end

endmodule // vsf_framer_bench

// Checker on the block's ports
bind vsf_framer vsf_framer_chk chk (
   .clk_i(clk_i), .stream_reset_n_i(stream_reset_n_i), .ctrl_clk_i(ctrl_clk_i),
   .stream_clock_enable_i(stream_clock_enable_i), .ctrl_reset_n_i(ctrl_reset_n_i),
   .control_port_clock_enable_i(control_port_clock_enable_i), .cfg_write_i(cfg_write_i),
   .cfg_ack_o(cfg_ack_o), .cfg_pending_o(cfg_pending_o), .s_axis_tvalid(s_axis_tvalid),
   .s_axis_tready(s_axis_tready), .s_axis_tuser(s_axis_tuser), .s_axis_tlast(s_axis_tlast),
   .m_axis_tvalid(m_axis_tvalid), .m_axis_tready(m_axis_tready), .m_axis_tuser(m_axis_tuser),
   .m_axis_tlast(m_axis_tlast), .parallel_event_lines_o(parallel_event_lines_o));
